// ### cisd_pkg.sv
/*
 * constants, codes and record layout for the two-channel current input
 * scaling and diagnostics block.
 * assumes a single 20 MHz clock and a same-clock analog front end.
 */
package cisd_pkg;

	localparam int CLK_NS     = 50;
	localparam int US_NS      = 1000;
	localparam int US_CYCLES  = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);

	localparam int N_CH       = 2;
	localparam int REC_BYTES  = 20;
	localparam int SHORT_BYTES = 4;
	localparam int TS_BYTE    = 16;

	typedef enum logic [1:0] {
		CISD_PATH_RECORD,
		CISD_PATH_INDEX,
		CISD_PATH_SUBINDEX
	} cisd_path_t;

	localparam logic [7:0] FN_OFF      = 8'hFF;
	localparam logic [7:0] FN_W0_20    = 8'h31;
	localparam logic [7:0] FN_N0_20    = 8'h41;
	localparam logic [7:0] FN_W4_20    = 8'h30;
	localparam logic [7:0] FN_N4_20    = 8'h40;
	localparam logic [7:0] FN_RESET    = 8'h30;

	localparam logic signed [31:0] SCALE_WIDE   = 32'sh0000_6C00;
	localparam logic signed [31:0] SCALE_NARROW = 32'sh0000_4000;
	localparam logic signed [31:0] SPAN_0_20_UA = 32'sh0000_4E20;
	localparam logic signed [31:0] SPAN_4_20_UA = 32'sh0000_3E80;
	localparam logic signed [31:0] LIVE_ZERO_UA = 32'sh0000_0FA0;
	localparam logic signed [31:0] OVR_WIDE     = 32'sh0000_7EFF;
	localparam logic signed [31:0] UND_WIDE     = 32'shFFFF_ED00;
	localparam logic signed [31:0] OVR_NARROW   = 32'sh0000_5000;
	localparam logic signed [31:0] UND_NARROW   = 32'shFFFF_F333;
	localparam logic [15:0] VAL_OVERFLOW  = 16'h7FFF;
	localparam logic [15:0] VAL_UNDERFLOW = 16'h8000;

	localparam logic [15:0] REC_SHORT  = 16'h0000;
	localparam logic [15:0] REC_FULL   = 16'h0001;
	localparam logic [15:0] REC_FN0    = 16'h0080;
	localparam logic [15:0] IDX_SHORT  = 16'h2F00;
	localparam logic [15:0] IDX_FULL   = 16'h2F01;
	localparam logic [15:0] IDX_FN0    = 16'h3100;
	localparam logic [15:0] IDX_SUBDIAG = 16'h5005;
	localparam logic [7:0]  SUB_FN0    = 8'h01;
	localparam logic [7:0]  SUB_FIRST  = 8'h02;
	localparam logic [7:0]  SUB_LASTB  = 8'h11;
	localparam logic [7:0]  SUB_TS     = 8'h13;

	localparam logic [7:0] MODINFO_RESET = 8'h15;
	localparam logic [7:0] CHKIND_RESET  = 8'h71;
	localparam logic [7:0] BITS_PER_CH   = 8'h08;
	localparam logic [7:0] CH_COUNT      = 8'h02;

	localparam int A_FAIL = 0;
	localparam int A_INT  = 1;
	localparam int A_EXT  = 2;
	localparam int A_CHAN = 3;
	localparam int A_AUX  = 4;
	localparam int A_PARM = 7;
	localparam int D_BUFOVF = 3;
	localparam int D_COMM   = 4;
	localparam int C_PARM = 0;
	localparam int C_UNF  = 6;
	localparam int C_OVF  = 7;

endpackage

// ### cisd_top.sv
/*
 * current input scaling and diagnostic record for a two-channel
 * 0/4..20 mA input module: scaling per function code, error flags,
 * microsecond ticker and record/index/subindex read and write port.
 * assumes the front end delivers signed microamp samples on ref_clk and
 * the coupler issues one request at a time on ref_clk.
 */
// Contract
// - code FFh disables channel, no conversion
// - code 31h scales 27648 per 20 mA
// - code 41h scales 16384 per 20 mA
// - code 30h scales 27648 over 4..20 mA
// - code 40h scales 16384 over 4..20 mA
// - errors light channel indicator, recorded, no interrupt
// - record 01h full, record 00h first four
// - index 2F01h full, index 2F00h first four
// - subindex path under 5005h from 02h
// - first diagnostic byte module error bits
// - module information class 0101b, bit4 set
// - fourth byte: buffer overflow, communication error (buffer overflow bit held at 0)
// - channel kind byte reads 71h
// - bits per channel reads 08h
// - channel count reads 02h
// - summary bit per channel group
// - detail bit0 parameter error
// - detail bit6 underflow, bit7 overflow
// - fixed record byte order, timestamp last
// - timestamp captures ticker at diagnostic event
// - ticker from zero, per microsecond, wraps
// - function codes reset to 30h
`timescale 1ns/1ns
module cisd_top
	import cisd_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic                  aux_supply_ok,
	input  wire logic                  sample_valid,
	input  wire logic [1:0][15:0]      sample_current_ua,
	input  wire logic                  req_valid,
	input  wire logic                  req_write,
	input  wire cisd_pkg::cisd_path_t  req_path,
	input  wire logic [15:0]           req_key,
	input  wire logic [7:0]            req_sub,
	input  wire logic [4:0]            req_byte,
	input  wire logic [7:0]            req_wdata,
	output logic                       rsp_valid,
	output logic [7:0]                 rsp_data,
	output logic                       rsp_error,
	output logic [1:0][15:0]           analog_value,
	output logic [1:0]                 chan_err_led,
	output logic                       module_err_led
);
	import cisd_pkg::*;

	logic              rst_a_reg;
	logic              rst_n;
	logic              aux_a_reg;
	logic              aux_ok_reg;
	logic [4:0]        presc_reg;
	logic [31:0]       us_reg;
	logic [1:0][7:0]   fn_reg;
	logic [1:0][7:0]   detail_reg;
	logic [1:0][7:0]   detail_next;
	logic [1:0][15:0]  value_reg;
	logic [1:0][15:0]  value_next;
	logic [31:0]       ts_reg;
	logic              comm_err_reg;
	logic              rsp_valid_reg;
	logic [7:0]        rsp_data_reg;
	logic              rsp_error_reg;
	logic [7:0]        err_a;
	logic [7:0]        err_d;
	logic [7:0]        ch_summary;
	logic [7:0]        rec [0:REC_BYTES-1];
	logic              diag_event;
	logic              fn_hit;
	logic              fn_sel;
	logic              diag_hit;
	logic [4:0]        diag_pos;

	// reset released through two flops so release is glitch free
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_a_reg <= 1'b0;
			rst_n     <= 1'b0;
		end
		else
		begin
			rst_a_reg <= 1'b1;
			rst_n     <= rst_a_reg;
		end
	end

	// aux supply pin is asynchronous to ref_clk
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aux_a_reg  <= 1'b0;
			aux_ok_reg <= 1'b0;
		end
		else
		begin
			aux_a_reg  <= aux_supply_ok;
			aux_ok_reg <= aux_a_reg;
		end
	end

	// free running microsecond ticker, wraps at 32 bits by overflow
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			presc_reg <= 5'h00;
			us_reg    <= 32'h0000_0000;
		end
		else if (presc_reg == US_LAST)
		begin
			presc_reg <= 5'h00;
			us_reg    <= us_reg + 32'h0000_0001;
		end
		else
		begin
			presc_reg <= presc_reg + 5'h01;
		end
	end

	// per channel scaling with round half away from zero
	for (genvar ch = 0; ch < N_CH; ch++)
	begin : g_ch
		logic signed [31:0] cur;
		logic signed [31:0] num;
		logic signed [31:0] den;
		logic signed [31:0] scaled;
		logic signed [31:0] ovr;
		logic signed [31:0] und;
		logic               known;

		assign cur = 32'(signed'(sample_current_ua[ch]));

		always_comb
		begin
			known = 1'b1;
			num   = 32'sh0000_0000;
			den   = SPAN_0_20_UA;
			ovr   = OVR_WIDE;
			und   = UND_WIDE;
			unique case (fn_reg[ch])
				FN_W0_20: num = SCALE_WIDE * cur;
				FN_N0_20:
				begin
					num = SCALE_NARROW * cur;
					ovr = OVR_NARROW;
					und = UND_NARROW;
				end
				FN_W4_20:
				begin
					num = SCALE_WIDE * (cur - LIVE_ZERO_UA);
					den = SPAN_4_20_UA;
				end
				FN_N4_20:
				begin
					num = SCALE_NARROW * (cur - LIVE_ZERO_UA);
					den = SPAN_4_20_UA;
					ovr = OVR_NARROW;
					und = UND_NARROW;
				end
				FN_OFF: known = 1'b1;
				default: known = 1'b0;
			endcase
			if (num < 0)
				scaled = (num - (den >>> 1)) / den;
			else
				scaled = (num + (den >>> 1)) / den;
			detail_next[ch] = 8'h00;
			value_next[ch]  = 16'h0000;
			if (fn_reg[ch] == FN_OFF)
			begin
				value_next[ch] = 16'h0000;
			end
			else if (!known)
			begin
				detail_next[ch][C_PARM] = 1'b1;
			end
			else if (scaled > ovr)
			begin
				detail_next[ch][C_OVF] = 1'b1;
				value_next[ch]         = VAL_OVERFLOW;
			end
			else if (scaled < und)
			begin
				detail_next[ch][C_UNF] = 1'b1;
				value_next[ch]         = VAL_UNDERFLOW;
			end
			else
			begin
				value_next[ch] = scaled[15:0];
			end
		end
	end

	// flags are rebuilt on every conversion, so they drop with their cause
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			detail_reg <= '0;
			value_reg  <= '0;
		end
		else if (sample_valid)
		begin
			detail_reg <= detail_next;
			value_reg  <= value_next;
		end
	end

	// an event is any detail flag newly raised at a conversion
	assign diag_event = sample_valid &&
		(|(detail_next & ~detail_reg));

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ts_reg <= 32'h0000_0000;
		else if (diag_event)
			ts_reg <= us_reg;
	end

	// record assembly
	assign ch_summary = {6'h00, |detail_reg[1], |detail_reg[0]};
	assign err_d = {3'h0, comm_err_reg, 1'b0, 3'h0};
	always_comb
	begin
		err_a         = 8'h00;
		err_a[A_PARM] = detail_reg[0][C_PARM] | detail_reg[1][C_PARM];
		err_a[A_CHAN] = |ch_summary;
		err_a[A_EXT]  = |(detail_reg[0][7:6] | detail_reg[1][7:6]);
		err_a[A_INT]  = |err_d;
		err_a[A_AUX]  = !aux_ok_reg;
		err_a[A_FAIL] = err_a[A_CHAN] | err_a[A_INT] | err_a[A_AUX];
	end

	always_comb
	begin
		for (int i = 0; i < REC_BYTES; i++)
			rec[i] = 8'h00;
		rec[0]  = err_a;
		rec[1]  = MODINFO_RESET;
		rec[3]  = err_d;
		rec[4]  = CHKIND_RESET;
		rec[5]  = BITS_PER_CH;
		rec[6]  = CH_COUNT;
		rec[7]  = ch_summary;
		rec[8]  = detail_reg[0];
		rec[9]  = detail_reg[1];
		rec[TS_BYTE]     = ts_reg[31:24];
		rec[TS_BYTE + 1] = ts_reg[23:16];
		rec[TS_BYTE + 2] = ts_reg[15:8];
		rec[TS_BYTE + 3] = ts_reg[7:0];
	end

	// address decode for the three access paths
	always_comb
	begin
		fn_hit   = 1'b0;
		fn_sel   = 1'b0;
		diag_hit = 1'b0;
		diag_pos = req_byte;
		unique case (req_path)
			CISD_PATH_RECORD:
			begin
				fn_hit = (req_key[15:1] == REC_FN0[15:1]) &&
					(req_byte == 5'h00);
				fn_sel = req_key[0];
				if (req_key == REC_FULL)
					diag_hit = req_byte < 5'(REC_BYTES);
				else if (req_key == REC_SHORT)
					diag_hit = req_byte < 5'(SHORT_BYTES);
			end
			CISD_PATH_INDEX:
			begin
				fn_hit = (req_key[15:1] == IDX_FN0[15:1]) &&
					(req_byte == 5'h00);
				fn_sel = req_key[0];
				if (req_key == IDX_FULL)
					diag_hit = req_byte < 5'(REC_BYTES);
				else if (req_key == IDX_SHORT)
					diag_hit = req_byte < 5'(SHORT_BYTES);
			end
			CISD_PATH_SUBINDEX:
			begin
				fn_hit = (req_key == IDX_FN0) && (req_byte == 5'h00) &&
					(req_sub == SUB_FN0 || req_sub == SUB_FIRST);
				fn_sel = (req_sub == SUB_FIRST);
				if (req_key == IDX_SUBDIAG)
				begin
					if (req_sub >= SUB_FIRST && req_sub <= SUB_LASTB &&
						req_byte == 5'h00)
					begin
						diag_hit = 1'b1;
						diag_pos = 5'(req_sub - SUB_FIRST);
					end
					else if (req_sub == SUB_TS &&
						req_byte < 5'(SHORT_BYTES))
					begin
						diag_hit = 1'b1;
						diag_pos = 5'(TS_BYTE) + req_byte;
					end
				end
			end
			default: ;
		endcase
	end

	// parameter writes; diagnostic bytes are read only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fn_reg <= {FN_RESET, FN_RESET};
		else if (req_valid && req_write && fn_hit)
			fn_reg[fn_sel] <= req_wdata;
	end

	// refused access raises the communication flag until a good one
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			comm_err_reg <= 1'b0;
		else if (req_valid)
			comm_err_reg <= !(fn_hit || (diag_hit && !req_write));
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= 8'h00;
			rsp_error_reg <= 1'b0;
		end
		else
		begin
			rsp_valid_reg <= req_valid;
			rsp_error_reg <= req_valid &&
				!(fn_hit || (diag_hit && !req_write));
			if (req_valid && fn_hit)
				rsp_data_reg <= req_write ? req_wdata : fn_reg[fn_sel];
			else if (req_valid && diag_hit && !req_write)
				rsp_data_reg <= rec[diag_pos];
			else
				rsp_data_reg <= 8'h00;
		end
	end

	assign rsp_valid      = rsp_valid_reg;
	assign rsp_data       = rsp_data_reg;
	assign rsp_error      = rsp_error_reg;
	assign analog_value   = value_reg;
	// indicators only; the block has no interrupt path at all
	assign chan_err_led   = ch_summary[1:0];
	assign module_err_led = err_a[A_FAIL];

	property p_off_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		sample_valid && fn_reg[0] == FN_OFF |=>
			analog_value[0] == 16'h0000 && detail_reg[0] == 8'h00;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("disabled channel produced a value or flag");

	property p_wide_full;
		@(posedge ref_clk) disable iff (!rst_n)
		sample_valid && fn_reg[0] == FN_W0_20 &&
		sample_current_ua[0] == 16'h4E20 |=>
			analog_value[0] == 16'h6C00;
	endproperty
	a_wide_full: assert property (p_wide_full)
		else $error("20 mA wide format is not 6C00h");

	property p_narrow_full;
		@(posedge ref_clk) disable iff (!rst_n)
		sample_valid && fn_reg[0] == FN_N0_20 &&
		sample_current_ua[0] == 16'h4E20 |=>
			analog_value[0] == 16'h4000;
	endproperty
	a_narrow_full: assert property (p_narrow_full)
		else $error("20 mA narrow format is not 4000h");

	property p_live_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		sample_valid && fn_reg[0] == FN_W4_20 &&
		sample_current_ua[0] == 16'h0FA0 |=>
			analog_value[0] == 16'h0000 && !chan_err_led[0];
	endproperty
	a_live_zero: assert property (p_live_zero)
		else $error("4 mA live zero is not zero");

	property p_narrow_under;
		@(posedge ref_clk) disable iff (!rst_n)
		sample_valid && fn_reg[1] == FN_N4_20 &&
		sample_current_ua[1] == 16'h0320 |=>
			analog_value[1] == 16'hF333 && !detail_reg[1][C_UNF];
	endproperty
	a_narrow_under: assert property (p_narrow_under)
		else $error("0.8 mA narrow live zero is not F333h");

	property p_short_limit;
		@(posedge ref_clk) disable iff (!rst_n)
		req_valid && !req_write && req_path == CISD_PATH_RECORD &&
		req_key == REC_SHORT && req_byte == 5'h04 |=>
			rsp_valid && rsp_error;
	endproperty
	a_short_limit: assert property (p_short_limit)
		else $error("short record served beyond four bytes");

	property p_index_modinfo;
		@(posedge ref_clk) disable iff (!rst_n)
		req_valid && !req_write && req_path == CISD_PATH_INDEX &&
		req_key == IDX_FULL && req_byte == 5'h01 |=>
			rsp_valid && !rsp_error && rsp_data == 8'h15;
	endproperty
	a_index_modinfo: assert property (p_index_modinfo)
		else $error("module information byte wrong on index path");

	property p_sub_count;
		@(posedge ref_clk) disable iff (!rst_n)
		req_valid && !req_write && req_path == CISD_PATH_SUBINDEX &&
		req_key == IDX_SUBDIAG && req_sub == 8'h08 &&
		req_byte == 5'h00 |=> rsp_data == 8'h02 && !rsp_error;
	endproperty
	a_sub_count: assert property (p_sub_count)
		else $error("channel count subindex did not read 02h");

	property p_summary;
		@(posedge ref_clk) disable iff (!rst_n)
		chan_err_led[1] == (detail_reg[1] != 8'h00) &&
		chan_err_led[0] == (detail_reg[0] != 8'h00) &&
		(module_err_led ||
			(detail_reg == '0 && aux_ok_reg && !comm_err_reg));
	endproperty
	a_summary: assert property (p_summary)
		else $error("summary flag differs from its details");

	property p_tick;
		@(posedge ref_clk) disable iff (!rst_n)
		presc_reg == US_LAST |=> us_reg == $past(us_reg) + 32'h0000_0001
			##1 us_reg == $past(us_reg);
	endproperty
	a_tick: assert property (p_tick)
		else $error("microsecond ticker step wrong");

	property p_stamp;
		@(posedge ref_clk) disable iff (!rst_n)
		diag_event |=> ts_reg == $past(us_reg);
	endproperty
	a_stamp: assert property (p_stamp)
		else $error("timestamp did not capture the ticker");

	property p_fn_reset;
		@(posedge ref_clk)
		$rose(rst_n) |-> fn_reg[0] == FN_RESET && fn_reg[1] == FN_RESET;
	endproperty
	a_fn_reset: assert property (p_fn_reset)
		else $error("function codes not 30h after reset");

endmodule

// ### cisd_coupler_model.sv
/*
 * coupler model: makes one read or write at a time on the record,
 * index and subindex port and hands back the answer.
 * assumes the block registers its answer on the taking edge, read back 1 ns after it.
 */
`timescale 1ns/1ns
module cisd_coupler_model
(
	input  wire logic            ref_clk,
	output logic                 req_valid,
	output logic                 req_write,
	output cisd_pkg::cisd_path_t req_path,
	output logic [15:0]          req_key,
	output logic [7:0]           req_sub,
	output logic [4:0]           req_byte,
	output logic [7:0]           req_wdata,
	input  wire logic            rsp_valid,
	input  wire logic [7:0]      rsp_data,
	input  wire logic            rsp_error
);
	import cisd_pkg::*;

	initial
	begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_path  = CISD_PATH_RECORD;
		req_key   = 16'h0000;
		req_sub   = 8'h00;
		req_byte  = 5'h00;
		req_wdata = 8'h00;
	end

	// the whole record is fetched by record 01h or index 2F01h
	task automatic xfer(
		input  logic        wr,
		input  cisd_path_t  pa,
		input  logic [15:0] k,
		input  logic [7:0]  s,
		input  logic [4:0]  b,
		input  logic [7:0]  wd,
		input  int          gap,
		output logic [7:0]  d,
		output logic        er,
		output logic        seen
	);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_path  <= pa;
		req_key   <= k;
		req_sub   <= s;
		req_byte  <= b;
		req_wdata <= wd;
		@(posedge ref_clk);
		// scrambled once released so a stale value never helps the block
		req_valid <= 1'b0;
		req_write <= ~wr;
		req_key   <= ~k;
		req_sub   <= ~s;
		req_byte  <= ~b;
		req_wdata <= ~wd;
		#1;
		seen = rsp_valid;
		d    = rsp_data;
		er   = rsp_error;
	endtask
endmodule

// ### tb_current_input_scaling_diag.sv
/*
 * self-checking bench for the current input scaling and diagnostic block.
 * assumes cisd_pkg and the coupler model are compiled first.
 */
`timescale 1ns/1ns
module tb_current_input_scaling_diag;
	import cisd_pkg::*;
	localparam cisd_path_t REC = CISD_PATH_RECORD;
	localparam cisd_path_t IDX = CISD_PATH_INDEX;
	localparam cisd_path_t SUB = CISD_PATH_SUBINDEX;
	localparam logic [9:0] ERR = 10'h300;
	logic             ref_clk;
	logic             nrst;
	logic             aux_supply_ok;
	logic             sample_valid;
	logic [1:0][15:0] sample_current_ua;
	logic             req_valid;
	logic             req_write;
	cisd_path_t       req_path;
	logic [15:0]      req_key;
	logic [7:0]       req_sub;
	logic [4:0]       req_byte;
	logic [7:0]       req_wdata;
	logic             rsp_valid;
	logic [7:0]       rsp_data;
	logic             rsp_error;
	logic [1:0][15:0] analog_value;
	logic [1:0]       chan_err_led;
	logic             module_err_led;
	int               bad_count;
	int               compares;
	int               cyc;
	int               t_us;
	int               gap;
	logic [31:0]      ts;
	logic [31:0]      ts_old;
	logic [9:0]       x;
	logic [7:0]       e;
	logic [7:0]       f;
	logic [7:0]       p0;
	logic [7:0]       p1;
	logic [7:0]  rst_rec [20] = '{1: 8'h15, 4: 8'h71, 5: 8'h08, 6: 8'h02,
		default: 8'h00};
	logic [7:0]  fn_tab [6] = '{8'h31, 8'h41, 8'h30, 8'h40, 8'hFF, 8'h55};
	logic [15:0] i0_tab [6] = '{16'h4E20, 16'h4E20, 16'h0FA0, 16'h0FA0,
		16'h4E20, 16'h4E20};
	logic [15:0] i1_tab [6] = '{16'h5C30, 16'h0320, 16'h0320, 16'h0320,
		16'h0320, 16'h0320};
	logic [15:0] v0_tab [6] = '{16'h6C00, 16'h4000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};
	logic [15:0] v1_tab [6] = '{16'h7FFF, 16'h028F, 16'h8000, 16'hF333,
		16'h0000, 16'h0000};
	logic [7:0]  d0_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
	logic [7:0]  d1_tab [6] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h00, 8'h01};

	cisd_top u_dut (.ref_clk(ref_clk), .nrst(nrst),
		.aux_supply_ok(aux_supply_ok), .sample_valid(sample_valid),
		.sample_current_ua(sample_current_ua), .req_valid(req_valid),
		.req_write(req_write), .req_path(req_path), .req_key(req_key),
		.req_sub(req_sub), .req_byte(req_byte), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
		.analog_value(analog_value), .chan_err_led(chan_err_led),
		.module_err_led(module_err_led));

	cisd_coupler_model u_cpl (.ref_clk(ref_clk), .req_valid(req_valid),
		.req_write(req_write), .req_path(req_path), .req_key(req_key),
		.req_sub(req_sub), .req_byte(req_byte), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error));

	initial
		ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	task automatic tally_and_finish;
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// the cycle ceiling is some fifty times what the sequence needs
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// x is {valid, error, data} as the answer should carry them
	task automatic acc(input logic wr, input cisd_path_t pa,
		input logic [15:0] k, input logic [7:0] s, input logic [4:0] b,
		input logic [7:0] wd, input logic [9:0] xp);
		logic [7:0] d;
		logic       er;
		logic       sn;
		u_cpl.xfer(wr, pa, k, s, b, wd, gap, d, er, sn);
		check({sn, er, d}, xp);
	endtask

	task automatic rd1(input logic [4:0] b, input logic [7:0] v);
		acc('0, REC, 16'h0001, '0, b, '0, {2'b10, v});
	endtask

	task automatic rd_ts(output logic [31:0] v);
		logic [7:0] d;
		logic       er;
		logic       sn;
		v = 32'h0000_0000;
		for (int b = 0; b < 4; b++)
		begin
			u_cpl.xfer('0, SUB, 16'h5005, 8'h13, 5'(b), '0, 0, d, er, sn);
			check({sn, er}, 2'b10);
			v = {v[23:0], d};
		end
	endtask

	task automatic convert(input logic [15:0] i0, input logic [15:0] i1);
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		sample_current_ua <= {i1, i0};
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		sample_current_ua <= ~{i1, i0};
		t_us = (cyc - 5) / 20;
		repeat (2) @(posedge ref_clk);
	endtask

	initial
	begin
		nrst = 1'b0;
		aux_supply_ok = 1'b1;
		sample_valid = 1'b0;
		sample_current_ua = '0;
		bad_count = 0;
		compares = 0;
		cyc = 0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int b = 0; b < 20; b++)
		begin
			gap = b % 3;
			x = {2'b10, rst_rec[b]};
			acc('0, REC, 16'h0001, '0, 5'(b), '0, x);
			acc('0, IDX, 16'h2F01, '0, 5'(b), '0, x);
			if (b < 4)
			begin
				acc('0, REC, 16'h0000, '0, 5'(b), '0, x);
				acc('0, IDX, 16'h2F00, '0, 5'(b), '0, x);
			end
			if (b < 16)
				acc('0, SUB, 16'h5005, 8'(b + 2), '0, '0, x);
			else
				acc('0, SUB, 16'h5005, 8'h13, 5'(b - 16), '0, x);
		end
		gap = 0;
		acc('0, REC, 16'h0080, '0, '0, '0, {2'b10, 8'h30});
		acc('0, IDX, 16'h3101, '0, '0, '0, {2'b10, 8'h30});
		acc('0, SUB, 16'h3100, 8'h01, '0, '0, {2'b10, 8'h30});
		acc('0, SUB, 16'h3100, 8'h00, '0, '0, ERR);
		acc(1'b1, REC, 16'h0001, '0, '0, 8'hA5, ERR);
		rd1(5'h03, 8'h10);
		rd1(5'h03, 8'h00);
		acc('0, REC, 16'h0000, '0, 5'h04, '0, ERR);
		rd1(5'h00, 8'h03);
		acc('0, REC, 16'h0002, '0, '0, '0, ERR);
		acc('0, IDX, 16'h2F00, '0, 5'h04, '0, ERR);
		acc('0, IDX, 16'h2F01, '0, 5'h14, '0, ERR);
		acc('0, SUB, 16'h5005, 8'h12, '0, '0, ERR);
		acc('0, SUB, 16'h5005, 8'h02, 5'h01, '0, ERR);
		rd1(5'h03, 8'h10);
		@(posedge ref_clk);
		aux_supply_ok <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check(module_err_led, 1'b1);
		rd1(5'h00, 8'h11);
		@(posedge ref_clk);
		aux_supply_ok <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd1(5'h00, 8'h00);
		p0 = 8'h00;
		p1 = 8'h00;
		ts_old = 32'h0000_0000;
		for (int r = 0; r < 6; r++)
		begin
			f = fn_tab[r];
			acc(1'b1, REC, 16'h0080, '0, '0, f, {2'b10, f});
			acc(1'b1, SUB, 16'h3100, 8'h02, '0, f, {2'b10, f});
			convert(i0_tab[r], i1_tab[r]);
			e = d0_tab[r] | d1_tab[r];
			check(analog_value[0], v0_tab[r]);
			check(analog_value[1], v1_tab[r]);
			x = {8'h00, d1_tab[r] != 8'h00, d0_tab[r] != 8'h00};
			check(chan_err_led, x[1:0]);
			check(module_err_led, e != 8'h00);
			rd1(5'h07, x[7:0]);
			rd1(5'h08, d0_tab[r]);
			rd1(5'h09, d1_tab[r]);
			rd1(5'h00, {e[0], 3'b000, e != 8'h00, |e[7:6], 1'b0,
				e != 8'h00});
			rd_ts(ts);
			if (((d0_tab[r] & ~p0) | (d1_tab[r] & ~p1)) != 8'h00)
				check(int'(ts) + 1 >= t_us && int'(ts) <= t_us + 1, 1);
			else
				check(ts, ts_old);
			ts_old = ts;
			p0 = d0_tab[r];
			p1 = d1_tab[r];
		end
		tally_and_finish();
	end
endmodule
